// ---- pxb_periph_model.sv ----
`timescale 1ns/1ns
module pxb_periph_model (
  // clock and control
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                emif_go,
  // far-side drive
  output pxb_pkg::pxb_periph_drv_t periph_drv,
  output pxb_pkg::pxb_emif_drv_t   emif_drv
);
  logic [31:0] cnt_q;
  // values move every cycle so a stale pin never matches by luck
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h9E3779B9;
  end
  // rx, miso, nss, rx1 and convert start are inputs only
  assign periph_drv.oe   = 16'h7DD5;
  assign periph_drv.out  = cnt_q[31:16] ^ cnt_q[15:0];
  assign emif_drv.active = emif_go;
  assign emif_drv.oe     = {32{emif_go}};
  assign emif_drv.out    = cnt_q;
endmodule // pxb_periph_model

// ---- pxb_pkg.sv ----
package pxb_pkg;

  // pin and signal geometry
  localparam int unsigned NUM_PORTS    = 8;
  localparam int unsigned NUM_LOWER    = 4;
  localparam int unsigned PORT_W       = 8;
  localparam int unsigned NUM_PINS     = NUM_PORTS * PORT_W;
  localparam int unsigned NUM_XPINS    = NUM_LOWER * PORT_W;
  localparam int unsigned NUM_SIGS     = 16;
  localparam int unsigned NUM_CEX      = 5;

  // crossbar signal slots, highest priority first
  localparam logic [3:0] SIG_TX0       = 4'h0;
  localparam logic [3:0] SIG_RX0       = 4'h1;
  localparam logic [3:0] SIG_SCK       = 4'h2;
  localparam logic [3:0] SIG_MISO      = 4'h3;
  localparam logic [3:0] SIG_MOSI      = 4'h4;
  localparam logic [3:0] SIG_NSS       = 4'h5;
  localparam logic [3:0] SIG_SDA       = 4'h6;
  localparam logic [3:0] SIG_SCL       = 4'h7;
  localparam logic [3:0] SIG_TX1       = 4'h8;
  localparam logic [3:0] SIG_RX1       = 4'h9;
  localparam logic [3:0] SIG_CEX0      = 4'hA;
  localparam logic [3:0] SIG_CNVST     = 4'hF;

  // register byte offsets
  localparam logic [7:0] OFS_DATA0     = 8'h00;
  localparam logic [7:0] OFS_MODE0     = 8'h20;
  localparam logic [7:0] OFS_BITACC    = 8'h40;
  localparam logic [7:0] OFS_XBAR      = 8'h44;
  localparam logic [7:0] OFS_ANALOG    = 8'h48;
  localparam logic [7:0] OFS_CFG       = 8'h4C;

  // crossbar enable register fields
  localparam int unsigned XB_SER0      = 0;
  localparam int unsigned XB_SPI       = 1;
  localparam int unsigned XB_SMB       = 2;
  localparam int unsigned XB_UART1     = 3;
  localparam int unsigned XB_PCA_LO    = 4;
  localparam int unsigned XB_CNVST     = 7;

  // bit access register fields
  localparam int unsigned BA_BIT_LO    = 0;
  localparam int unsigned BA_PORT_LO   = 3;
  localparam int unsigned BA_VAL       = 5;

  // configuration register fields
  localparam int unsigned CFG_EMIF_UP  = 0;
  localparam int unsigned CFG_WEAK_DIS = 1;

  // reset values
  localparam logic [7:0] RST_DATA      = 8'hFF;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_XBAR      = 8'h00;
  localparam logic [7:0] RST_ANALOG    = 8'h00;
  localparam logic [7:0] RST_CFG       = 8'h00;

  typedef struct packed {
    logic [NUM_SIGS-1:0] out;
    logic [NUM_SIGS-1:0] oe;
  } pxb_periph_drv_t;

  typedef struct packed {
    logic [NUM_XPINS-1:0] out;
    logic [NUM_XPINS-1:0] oe;
    logic                 active;
  } pxb_emif_drv_t;

endpackage

// ---- pxb_port_io.sv ----
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// RULE_01: each lower-port pin is general purpose or driven by a peripheral.
// RULE_02: port data reads return present pin levels in every pin role; analog pins read 0 here.
// RULE_03: lower ports allow bit and byte access, upper ports byte only.
// RULE_04: every pin has open-drain or push-pull drive and weak pull-up.
// RULE_05: crossbar gives out pins in order from first to last lower pin.
// RULE_06: peripherals served by fixed priority, first serial port first.
// RULE_07: external memory bus drives lower or upper port group as set.
// RULE_08: second port pins can be analog inputs to secondary converter.
// RULE_09: a peripheral reaches pins only when its enable bits are one.
// RULE_10: an enabled serial peripheral gets all its signals at once.
// RULE_11: unclaimed lower pins stay general purpose from the data latch.
module pxb_port_io (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  // digital peripherals
  input  wire pxb_pkg::pxb_periph_drv_t periph_drv,
  output logic      [15:0]            periph_in,
  // external memory interface
  input  wire pxb_pkg::pxb_emif_drv_t  emif_drv,
  // pins
  input  wire logic [63:0]            pin_in,
  output logic      [63:0]            pin_out,
  output logic      [63:0]            pin_oe,
  output logic      [63:0]            pin_pullup_en,
  // secondary_analog_converter channel select
  output logic      [7:0]             analog_sel
);

  logic [7:0][7:0]  data_q;
  logic [7:0][7:0]  mode_q;
  logic [7:0]       xbar_q;
  logic [7:0]       analog_q;
  logic [7:0]       cfg_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [63:0]      sync1_q;
  logic [63:0]      sync2_q;
  logic [63:0]      pin_out_q;
  logic [63:0]      pin_oe_q;
  logic [63:0]      pullup_q;
  logic [15:0]      periph_in_q;
  logic [63:0]      pin_out_d;
  logic [63:0]      pin_oe_d;
  logic [63:0]      pullup_d;
  logic [15:0]      periph_in_d;
  logic [31:0]      rdata_d;
  logic [7:0][7:0]  data_d;

  // bus decode
  wire        req       = cyc_i & stb_i & ~ack_q;
  // writes land on the edge where the master samples ack, while the
  // address and data still stand
  wire        wr_strobe = cyc_i & stb_i & ack_q & we_i & sel_i[0];
  wire [2:0]  reg_idx   = adr_i[4:2];
  wire        hit_data  = adr_i[7:5] == pxb_pkg::OFS_DATA0[7:5];
  wire        hit_mode  = adr_i[7:5] == pxb_pkg::OFS_MODE0[7:5];
  wire        hit_bit   = adr_i == pxb_pkg::OFS_BITACC;
  wire        hit_xbar  = adr_i == pxb_pkg::OFS_XBAR;
  wire        hit_anlg  = adr_i == pxb_pkg::OFS_ANALOG;
  wire        hit_cfg   = adr_i == pxb_pkg::OFS_CFG;
  wire        aligned   = adr_i[1:0] == 2'h0;

  // bit access only carries a two-bit port number, so upper ports
  // cannot be reached this way
  wire [1:0]  ba_port   = dat_i[pxb_pkg::BA_PORT_LO +: 2];       // RULE_03
  wire [2:0]  ba_bit    = dat_i[pxb_pkg::BA_BIT_LO +: 3];
  wire        ba_val    = dat_i[pxb_pkg::BA_VAL];

  // crossbar slot enables; serial peripherals claim whole groups
  wire        en_ser0   = xbar_q[pxb_pkg::XB_SER0];              // RULE_09
  wire        en_spi    = xbar_q[pxb_pkg::XB_SPI];
  wire        en_smb    = xbar_q[pxb_pkg::XB_SMB];
  wire        en_uart1  = xbar_q[pxb_pkg::XB_UART1];
  wire [2:0]  pca_cnt   = xbar_q[pxb_pkg::XB_PCA_LO +: 3];
  wire        en_cnvst  = xbar_q[pxb_pkg::XB_CNVST];
  wire [15:0] sig_en;
  wire [4:0]  cex_en;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_cex
      assign cex_en[g] = pca_cnt > 3'(g);
    end
  endgenerate

  assign sig_en = {en_cnvst, cex_en, {2{en_uart1}}, {2{en_smb}},
                   {4{en_spi}}, {2{en_ser0}}};                  // RULE_10

  wire [31:0]      pin_claim;
  wire [31:0][3:0] pin_sig;
  wire [15:0][4:0] sig_pin;

  pxb_xbar_alloc u_alloc (
    .sig_en    (sig_en),
    .pin_claim (pin_claim),
    .pin_sig   (pin_sig),
    .sig_pin   (sig_pin)
  );

  wire emif_lower = emif_drv.active & ~cfg_q[pxb_pkg::CFG_EMIF_UP];
  wire emif_upper = emif_drv.active & cfg_q[pxb_pkg::CFG_EMIF_UP];
  wire weak_dis   = cfg_q[pxb_pkg::CFG_WEAK_DIS];
  wire [63:0] analog_pin = {48'h0, analog_q, 8'h00};             // RULE_08

  // per-pin source selection and driver style
  always_comb begin
    logic val;
    logic drive;
    val       = 1'b1;
    drive     = 1'b0;
    pin_out_d = '0;
    pin_oe_d  = '0;
    pullup_d  = '0;
    for (int p = 0; p < 64; p++) begin
      val   = data_q[p/8][p%8];                                  // RULE_11
      drive = 1'b1;
      // indices folded into range so unreachable selects stay legal
      if (p < 32 && pin_claim[p%32]) begin
        val   = periph_drv.out[pin_sig[p%32]];                   // RULE_01
        drive = periph_drv.oe[pin_sig[p%32]];
      end
      if (analog_pin[p]) begin
        drive = 1'b0;
      end
      if (p < 32 && emif_lower) begin
        val   = emif_drv.out[p%32];                              // RULE_07
        drive = emif_drv.oe[p%32];
      end
      if (p >= 32 && emif_upper) begin
        val   = emif_drv.out[p%32];                              // RULE_07
        drive = emif_drv.oe[p%32];
      end
      // open-drain only ever pulls low; push-pull drives both levels
      pin_out_d[p] = val;
      pin_oe_d[p]  = drive & (mode_q[p/8][p%8] | ~val);          // RULE_04
      pullup_d[p]  = ~weak_dis & ~analog_pin[p] &
                     ~(drive & ~val);                            // RULE_04
    end
  end

  // unplaced inputs idle high
  always_comb begin
    periph_in_d = '1;
    for (int s = 0; s < 16; s++) begin
      if (sig_en[s]) begin
        periph_in_d[s] = sync2_q[sig_pin[s]];
      end
    end
  end

  // register writes
  always_comb begin
    data_d = data_q;
    if (wr_strobe && aligned && hit_data) begin
      data_d[reg_idx] = dat_i[7:0];
    end
    if (wr_strobe && hit_bit) begin
      data_d[{1'b0, ba_port}][ba_bit] = ba_val;                  // RULE_03
    end
  end

  // read mux; analog pins read low since their digital input is off
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (aligned && hit_data) begin
      rdata_d[7:0] = sync2_q[reg_idx*8 +: 8] &
                     ~analog_pin[reg_idx*8 +: 8];                // RULE_02
    end else if (aligned && hit_mode) begin
      rdata_d[7:0] = mode_q[reg_idx];
    end else if (hit_xbar) begin
      rdata_d[7:0] = xbar_q;
    end else if (hit_anlg) begin
      rdata_d[7:0] = analog_q;
    end else if (hit_cfg) begin
      rdata_d[7:0] = cfg_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q   <= {8{pxb_pkg::RST_DATA}};
      mode_q   <= {8{pxb_pkg::RST_MODE}};
      xbar_q   <= pxb_pkg::RST_XBAR;
      analog_q <= pxb_pkg::RST_ANALOG;
      cfg_q    <= pxb_pkg::RST_CFG;
    end else begin
      data_q <= data_d;
      if (wr_strobe && aligned && hit_mode) begin
        mode_q[reg_idx] <= dat_i[7:0];
      end
      if (wr_strobe && hit_xbar) begin
        xbar_q <= dat_i[7:0];
      end
      if (wr_strobe && hit_anlg) begin
        analog_q <= dat_i[7:0];
      end
      if (wr_strobe && hit_cfg) begin
        cfg_q <= dat_i[7:0];
      end
    end
  end

  // one-cycle answer; ack drops the cycle after it was given
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= rdata_d;
      end
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 64'hFFFF_FFFF_FFFF_FFFF;
      sync2_q <= 64'hFFFF_FFFF_FFFF_FFFF;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out_q   <= 64'hFFFF_FFFF_FFFF_FFFF;
      pin_oe_q    <= 64'h0000_0000_0000_0000;
      pullup_q    <= 64'hFFFF_FFFF_FFFF_FFFF;
      periph_in_q <= 16'hFFFF;
    end else begin
      pin_out_q   <= pin_out_d;
      pin_oe_q    <= pin_oe_d;
      pullup_q    <= pullup_d;
      periph_in_q <= periph_in_d;
    end
  end

  assign dat_o         = dat_q;
  assign ack_o         = ack_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign pin_pullup_en = pullup_q;
  assign periph_in     = periph_in_q;
  assign analog_sel    = analog_q;                               // RULE_08

endmodule // pxb_port_io

// ---- pxb_port_io_bench.sv ----
`timescale 1ns/1ns
module pxb_port_io_bench;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic        cyc_i = 1'h0;
  logic        stb_i = 1'h0;
  logic        we_i = 1'h0;
  logic        emif_go = 1'h0;
  logic [3:0]  sel_i = 4'h1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] periph_in;
  logic [63:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [7:0]  analog_sel;
  int          error_cnt = 0;
  int          cmp_count = 0;
  pxb_pkg::pxb_periph_drv_t periph_drv;
  pxb_pkg::pxb_emif_drv_t   emif_drv;
  // level of an undriven pin once its pull-up is off
  wire logic [63:0] ext_lvl = 64'h96F0_3CA5_5A0F_C369;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | ext_lvl));
  always #4 clock = ~clock;
  pxb_port_io dut (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .periph_drv, .periph_in, .emif_drv, .pin_in,
    .pin_out, .pin_oe, .pin_pullup_en, .analog_sel);
  pxb_periph_model u_peer (.clock, .rst, .emif_go, .periph_drv, .emif_drv);
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [7:0] q);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'h1 && n < 64);
    q = dat_o[7:0];
    if (n == 64) error_cnt++;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, e);
    logic [7:0] q;
    wb(1'h0, a, 8'h00, q);
    chk(nm, 64'(e), 64'(q));
  endtask
  task automatic t_gpio();
    rd("xbar rst", 8'h44, 8'h00);
    rd("port0 rst", 8'h00, 8'hFF);
    wr(8'h00, 8'h5A);
    wr(8'h14, 8'h3C);
    wr(8'h40, 8'h13);
    wr(8'h80, 8'h55);
    repeat (4) @(posedge clock);
    rd("port0", 8'h00, 8'h5A);
    rd("port5", 8'h14, 8'h3C);
    rd("bit write", 8'h08, 8'hF7);
    rd("bit reg", 8'h40, 8'h00);
    rd("unmapped", 8'h80, 8'h00);
  endtask
  task automatic t_mode();
    wr(8'h20, 8'hFF);
    repeat (3) @(posedge clock);
    chk("pp oe", 64'hFF, 64'(pin_oe[7:0]));
    chk("pp out", 64'h5A, 64'(pin_out[7:0]));
    chk("pull", 64'h5A, 64'(pin_pullup_en[7:0]));
    wr(8'h20, 8'h00);
    wr(8'h4C, 8'h02);
    repeat (3) @(posedge clock);
    chk("od oe", 64'hA5, 64'(pin_oe[7:0]));
    chk("no pull", 64'h0, 64'(pin_pullup_en[7:0]));
  endtask
  task automatic t_xbar();
    logic [7:0] cfg [5] = '{8'h01, 8'h0A, 8'h96, 8'hFF, 8'h00};
    logic [7:0] pat = 8'hC3;
    pxb_pkg::pxb_periph_drv_t d;
    logic [63:0] po, pe;
    logic [15:0] pi;
    logic en;
    int p;
    for (int k = 0; k < 4; k++) begin
      wr(8'(4 * k), pat);
      wr(8'(8'h20 + 4 * k), 8'hFF);
    end
    foreach (cfg[c]) begin
      wr(8'h44, cfg[c]);
      repeat (5) @(posedge clock);
      d = periph_drv;
      @(posedge clock);
      po = pin_out;
      pe = pin_oe;
      pi = periph_in;
      p = 0;
      for (int s = 0; s < 16; s++) begin
        en = s < 2 ? cfg[c][0] : s < 6 ? cfg[c][1] : s < 8 ? cfg[c][2] :
             s < 10 ? cfg[c][3] : s < 15 ? (s - 10) < cfg[c][6:4] : cfg[c][7];
        if (!en) chk("idle", 64'h1, 64'(pi[s]));
        else begin
          chk("slot oe", 64'(d.oe[s]), 64'(pe[p]));
          if (d.oe[s]) chk("slot out", 64'(d.out[s]), 64'(po[p]));
          else chk("slot in", 64'(ext_lvl[p]), 64'(pi[s]));
          p++;
        end
      end
      while (p < 32) begin
        chk("gpio", 64'(pat[p % 8]), 64'(po[p]));
        p++;
      end
    end
  endtask
  task automatic t_analog();
    wr(8'h48, 8'h0F);
    repeat (4) @(posedge clock);
    chk("ana sel", 64'h0F, 64'(analog_sel));
    chk("ana oe", 64'h0, 64'(pin_oe[11:8]));
    rd("ana rd", 8'h04, 8'hC0);
    wr(8'h48, 8'h00);
  endtask
  task automatic t_emif();
    logic [31:0] d;
    for (int k = 4; k < 8; k++) wr(8'(8'h20 + 4 * k), 8'hFF);
    emif_go <= 1'h1;
    for (int g = 0; g < 2; g++) begin
      wr(8'h4C, 8'(g));
      repeat (3) @(posedge clock);
      d = emif_drv.out;
      @(posedge clock);
      chk("emif out", 64'(d), 64'(pin_out[32 * g +: 32]));
      chk("emif oe", 64'hFFFFFFFF, 64'(pin_oe[32 * g +: 32]));
    end
    emif_go <= 1'h0;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_gpio();
    t_mode();
    t_xbar();
    t_analog();
    t_emif();
    give_verdict();
  end
  // the run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
endmodule // pxb_port_io_bench
bind pxb_port_io pxb_port_io_checker u_chk (.clock, .rst, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .periph_in, .pin_out,
  .pin_oe, .pin_pullup_en, .analog_sel);

// ---- pxb_port_io_checker.sv ----
`timescale 1ns/1ns
module pxb_port_io_checker (
  // bus
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // pins and peripherals
  input wire logic [15:0] periph_in,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] pin_pullup_en,
  input wire logic [7:0]  analog_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic tk = cyc_i && stb_i && !ack_o;
  wire logic wr = ack_o && cyc_i && stb_i && we_i && sel_i[0];
  logic [7:0] xb_q;
  logic [7:0] an_q;
  logic [2:0] age_q;
  // shadow copies; age saturates so it never wraps into a false pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xb_q  <= 8'h00;
      an_q  <= 8'h00;
      age_q <= 3'h0;
    end else begin
      if (wr && adr_i == 8'h44) xb_q <= dat_i[7:0];
      if (wr && adr_i == 8'h48) an_q <= dat_i[7:0];
      age_q <= wr ? 3'h0 : age_q + 3'(age_q != 3'h7);
    end
  end
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack; tk |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late or long");
  property p_cause; ack_o |-> $past(tk); endproperty
  a_cause: assert property (p_cause) else $error("stray ack");
  property p_hold; !tk |=> $stable(dat_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_hi; dat_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_unmap;
    tk && !we_i && (adr_i > 8'h4F || adr_i == 8'h40) |=> dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("empty read not 0");
  property p_pull; (pin_oe & ~pin_out & pin_pullup_en) == 64'h0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on low");
  property p_idle;
    xb_q == 8'h00 && age_q > 3'h4 |-> periph_in == 16'hFFFF;
  endproperty
  a_idle: assert property (p_idle) else $error("slot without pin");
  property p_ana; age_q > 3'h1 |-> analog_sel == an_q; endproperty
  a_ana: assert property (p_ana) else $error("analog select");
  property p_anapull;
    age_q > 3'h1 |-> (pin_pullup_en[15:8] & an_q) == 8'h00;
  endproperty
  a_anapull: assert property (p_anapull) else $error("analog pull-up");
endmodule // pxb_port_io_checker

// ---- pxb_xbar_alloc.sv ----
`timescale 1ns/1ns
module pxb_xbar_alloc (
  // enabled signal slots in priority order
  input  wire logic [15:0]      sig_en,
  // pin side
  output logic      [31:0]      pin_claim,
  output logic      [31:0][3:0] pin_sig,
  // signal side
  output logic      [15:0][4:0] sig_pin
);

  logic [5:0] pos;

  // pins handed out in order from the lowest one, by slot priority
  always_comb begin
    pos       = 6'h00;
    pin_claim = '0;
    pin_sig   = '0;
    sig_pin   = '0;
    for (int s = 0; s < 16; s++) begin
      if (sig_en[s]) begin
        sig_pin[s]           = pos[4:0];  // RULE_05
        pin_claim[pos[4:0]]  = 1'b1;
        pin_sig[pos[4:0]]    = 4'(s);     // RULE_06
        pos                  = 6'(pos + 6'h01);
      end
    end
  end

endmodule // pxb_xbar_alloc
